// [inc/pamux_pkg.sv]
// Constants, register map and types for the Port A external memory pin override
// ==========================================================================
// Summary of operation
// - With external memory on, pin n carries bit n of muxed address/data bus.
// - Pull-up override enable on every pin equals the external memory enable.
// - Pull-up override value is not(write or address), latch bit and global pull-up off.
// - Direction override enable on every pin equals the external memory enable.
// - Direction override value is write phase or address phase.
// - Level override enable on every pin equals the external memory enable.
// - Level override value is address bit during address, or write bit during write.
// - Input gate override enable is held low on all pins.
// - Input gate override value is tied low on all pins.
// - Each pin's input is routed to the memory interface as read data bit n.
// - Address phase is high exactly while the address is driven on the pins.
// - Without pull-up override, pull-up on only for direction 0, latch 1, off 0.
// - Driver follows direction bit unless direction override is enabled.
// - With level override enabled, pin level is override value, else latch.
package pamux_pkg;

	// ======================================================================
	// Widths and timing
	localparam int          PIN_COUNT      = 8;
	localparam int          BUS_AW         = 8;
	localparam int          BUS_DW         = 8;
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          ADDR_TIME_NS   = 20;
	localparam int          DATA_TIME_NS   = 30;
	localparam int          ADDR_CYC_RAW   = (ADDR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          DATA_CYC_RAW   = (DATA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ADDR_CYC       = (ADDR_CYC_RAW < 1) ? 1 : ADDR_CYC_RAW;
	localparam int          DATA_CYC       = (DATA_CYC_RAW < 1) ? 1 : DATA_CYC_RAW;
	localparam int          CNT_W          = 4;

	// ======================================================================
	// Register offsets
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_LATCH      = 8'h04;
	localparam logic [7:0]  REG_DIR        = 8'h08;
	localparam logic [7:0]  REG_PINS       = 8'h0C;
	localparam logic [7:0]  REG_MADDR      = 8'h10;
	localparam logic [7:0]  REG_MWDATA     = 8'h14;
	localparam logic [7:0]  REG_MCMD       = 8'h18;
	localparam logic [7:0]  REG_MSTAT      = 8'h1C;
	localparam logic [7:0]  REG_MRDATA     = 8'h20;

	// ======================================================================
	// Field positions
	localparam int          CTRL_EME_BIT   = 0;
	localparam int          CTRL_PUD_BIT   = 1;
	localparam int          CMD_START_BIT  = 0;
	localparam int          CMD_WRITE_BIT  = 1;
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_DONE_BIT  = 1;

	// ======================================================================
	// Reset values
	localparam logic [7:0]  BYTE_RESET     = 8'h00;
	localparam logic [7:0]  READ_ZERO      = 8'h00;

	typedef enum logic [1:0] {
		PAMUX_IDLE,
		PAMUX_ADDR,
		PAMUX_WRITE,
		PAMUX_READ
	} pamux_state_t;

endpackage

// [inc/pamux_ovr_if.sv]
// Override signal bundle between the memory sequencer and the override generator
`timescale 1ns/1ps
interface pamux_ovr_if;
	logic       ext_mem_enable;
	logic       pullup_global_off;
	logic       address_phase;
	logic       write_phase;
	logic [7:0] addr_byte;
	logic [7:0] wdata_byte;
	logic [7:0] out_latch_bit;
	logic [7:0] pin_input_tap;
	logic [7:0] pullup_override_enable;
	logic [7:0] pullup_override_value;
	logic [7:0] direction_override_enable;
	logic [7:0] direction_override_value;
	logic [7:0] level_override_enable;
	logic [7:0] level_override_value;
	logic [7:0] input_gate_override_enable;
	logic [7:0] input_gate_override_value;
	logic [7:0] mem_read_data;

	modport gen (
		input  ext_mem_enable,
		input  pullup_global_off,
		input  address_phase,
		input  write_phase,
		input  addr_byte,
		input  wdata_byte,
		input  out_latch_bit,
		input  pin_input_tap,
		output pullup_override_enable,
		output pullup_override_value,
		output direction_override_enable,
		output direction_override_value,
		output level_override_enable,
		output level_override_value,
		output input_gate_override_enable,
		output input_gate_override_value,
		output mem_read_data
	);

	modport use_side (
		output ext_mem_enable,
		output pullup_global_off,
		output address_phase,
		output write_phase,
		output addr_byte,
		output wdata_byte,
		output out_latch_bit,
		output pin_input_tap,
		input  pullup_override_enable,
		input  pullup_override_value,
		input  direction_override_enable,
		input  direction_override_value,
		input  level_override_enable,
		input  level_override_value,
		input  input_gate_override_enable,
		input  input_gate_override_value,
		input  mem_read_data
	);
endinterface

// [rtl/pamux_ovr_gen.sv]
// Override signal generator for the eight Port A pins
`timescale 1ns/1ps
module pamux_ovr_gen (
	pamux_ovr_if.gen ovr
);
	// ======================================================================
	// Override terms, one per pin
	genvar n;
	generate
		for (n = 0; n < pamux_pkg::PIN_COUNT; n++) begin : g_pin
			assign ovr.pullup_override_enable[n]     = ovr.ext_mem_enable;
			assign ovr.pullup_override_value[n]      = ~(ovr.write_phase | ovr.address_phase)
				& ovr.out_latch_bit[n] & ovr.pullup_global_off;
			assign ovr.direction_override_enable[n]  = ovr.ext_mem_enable;
			assign ovr.direction_override_value[n]   = ovr.write_phase | ovr.address_phase;
			assign ovr.level_override_enable[n]      = ovr.ext_mem_enable;
			assign ovr.level_override_value[n]       = (ovr.addr_byte[n] & ovr.address_phase)
				| (ovr.wdata_byte[n] & ovr.write_phase);
			assign ovr.input_gate_override_enable[n] = 1'b0;
			assign ovr.input_gate_override_value[n]  = 1'b0;
			assign ovr.mem_read_data[n]              = ovr.pin_input_tap[n];
		end
	endgenerate
endmodule

// [rtl/pamux_top.sv]
// Port A pin control with external memory override, registers and access sequencer
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module pamux_top #(
	parameter int ADDR_CYC = pamux_pkg::ADDR_CYC,
	parameter int DATA_CYC = pamux_pkg::DATA_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_we,
	input  wire logic       bus_re,
	output logic      [7:0] bus_rdata,
	input  wire logic       sleep_mode,
	input  wire logic [7:0] pin_in,
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe_n,
	output logic      [7:0] pin_pullup_on,
	output logic      [7:0] pin_input_enable,
	output logic            address_phase,
	output logic            write_phase,
	output logic            read_phase
);
	// ======================================================================
	// Register state
	logic                      ext_mem_enable_q;
	logic                      pullup_global_off_q;
	logic [7:0]                out_latch_q;
	logic [7:0]                direction_q;
	logic [7:0]                mem_addr_q;
	logic [7:0]                mem_wdata_q;
	logic [7:0]                mem_rdata_q;
	logic                      mem_done_q;
	logic [7:0]                bus_rdata_q;
	logic [7:0]                sync1_q;
	logic [7:0]                sync2_q;
	logic [7:0]                sync3_q;
	logic [7:0]                pin_state_q;
	pamux_pkg::pamux_state_t   state_q;
	logic [pamux_pkg::CNT_W-1:0] cnt_q;
	logic                      start_req;
	logic                      start_write;
	logic                      access_end;
	logic [7:0]                drive_en;
	logic                      mem_cmd_write_q;

	// Local aliases of the sequencer states
	localparam pamux_pkg::pamux_state_t PAMUX_IDLE_A  = pamux_pkg::PAMUX_IDLE;
	localparam pamux_pkg::pamux_state_t PAMUX_ADDR_A  = pamux_pkg::PAMUX_ADDR;
	localparam pamux_pkg::pamux_state_t PAMUX_WRITE_A = pamux_pkg::PAMUX_WRITE;
	localparam pamux_pkg::pamux_state_t PAMUX_READ_A  = pamux_pkg::PAMUX_READ;

	pamux_ovr_if ovr ();

	// ======================================================================
	// Override generator
	pamux_ovr_gen u_gen (
		.ovr (ovr)
	);

	assign ovr.ext_mem_enable    = ext_mem_enable_q;
	assign ovr.pullup_global_off = pullup_global_off_q;
	assign ovr.address_phase     = address_phase;
	assign ovr.write_phase       = write_phase;
	assign ovr.addr_byte         = mem_addr_q;
	assign ovr.wdata_byte        = mem_wdata_q;
	assign ovr.out_latch_bit     = out_latch_q;
	assign ovr.pin_input_tap     = pin_in;

	// ======================================================================
	// Register writes
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_mem_enable_q    <= 1'b0;
			pullup_global_off_q <= 1'b0;
		end else if (bus_we && bus_addr == pamux_pkg::REG_CTRL) begin
			ext_mem_enable_q    <= bus_wdata[pamux_pkg::CTRL_EME_BIT];
			pullup_global_off_q <= bus_wdata[pamux_pkg::CTRL_PUD_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_latch_q <= pamux_pkg::BYTE_RESET;
		end else if (bus_we && bus_addr == pamux_pkg::REG_LATCH) begin
			out_latch_q <= bus_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			direction_q <= pamux_pkg::BYTE_RESET;
		end else if (bus_we && bus_addr == pamux_pkg::REG_DIR) begin
			direction_q <= bus_wdata;
		end
	end

	// Address and write data held while an access runs
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_addr_q  <= pamux_pkg::BYTE_RESET;
			mem_wdata_q <= pamux_pkg::BYTE_RESET;
		end else if (state_q == PAMUX_IDLE_A) begin
			if (bus_we && bus_addr == pamux_pkg::REG_MADDR) begin
				mem_addr_q <= bus_wdata;
			end
			if (bus_we && bus_addr == pamux_pkg::REG_MWDATA) begin
				mem_wdata_q <= bus_wdata;
			end
		end
	end

	// ======================================================================
	// Pin input filter: change accepted once second and third stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q     <= pamux_pkg::BYTE_RESET;
			sync2_q     <= pamux_pkg::BYTE_RESET;
			sync3_q     <= pamux_pkg::BYTE_RESET;
			pin_state_q <= pamux_pkg::BYTE_RESET;
		end else begin
			sync1_q <= ovr.mem_read_data;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (int i = 0; i < pamux_pkg::PIN_COUNT; i++) begin
				if (sync2_q[i] == sync3_q[i]) begin
					pin_state_q[i] <= sync3_q[i];
				end
			end
		end
	end

	// ======================================================================
	// Access sequencer
	assign start_req   = bus_we && bus_addr == pamux_pkg::REG_MCMD
		&& bus_wdata[pamux_pkg::CMD_START_BIT] && ext_mem_enable_q
		&& state_q == PAMUX_IDLE_A;
	assign start_write = bus_wdata[pamux_pkg::CMD_WRITE_BIT];
	assign access_end  = (state_q == PAMUX_WRITE_A || state_q == PAMUX_READ_A)
		&& cnt_q == pamux_pkg::CNT_W'(DATA_CYC - 1);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= PAMUX_IDLE_A;
			cnt_q   <= '0;
		end else begin
			unique case (state_q)
				PAMUX_IDLE_A: begin
					cnt_q <= '0;
					if (start_req) begin
						state_q <= PAMUX_ADDR_A;
					end
				end
				PAMUX_ADDR_A: begin
					if (cnt_q == pamux_pkg::CNT_W'(ADDR_CYC - 1)) begin
						cnt_q   <= '0;
						state_q <= mem_cmd_write_q ? PAMUX_WRITE_A : PAMUX_READ_A;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				PAMUX_WRITE_A, PAMUX_READ_A: begin
					if (access_end) begin
						cnt_q   <= '0;
						state_q <= PAMUX_IDLE_A;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
			endcase
		end
	end

	// Direction of the access taken with the start command
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_cmd_write_q <= 1'b0;
		end else if (start_req) begin
			mem_cmd_write_q <= start_write;
		end
	end

	assign address_phase = state_q == PAMUX_ADDR_A;
	assign write_phase   = state_q == PAMUX_WRITE_A;
	assign read_phase    = state_q == PAMUX_READ_A;

	// Read data capture and done flag, set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_rdata_q <= pamux_pkg::BYTE_RESET;
		end else if (access_end && state_q == PAMUX_READ_A) begin
			mem_rdata_q <= pin_state_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mem_done_q <= 1'b0;
		end else if (access_end) begin
			mem_done_q <= 1'b1;
		end else if (bus_we && bus_addr == pamux_pkg::REG_MSTAT
			&& bus_wdata[pamux_pkg::STAT_DONE_BIT]) begin
			mem_done_q <= 1'b0;
		end
	end

	// ======================================================================
	// Pin resolution per pin
	genvar n;
	generate
		for (n = 0; n < pamux_pkg::PIN_COUNT; n++) begin : g_pin
			assign drive_en[n] = ovr.direction_override_enable[n]
				? ovr.direction_override_value[n] : direction_q[n];
			assign pin_oe_n[n] = ~drive_en[n];
			assign pin_out[n]  = ovr.level_override_enable[n]
				? ovr.level_override_value[n] : out_latch_q[n];
			assign pin_pullup_on[n] = ovr.pullup_override_enable[n]
				? ovr.pullup_override_value[n]
				: (~direction_q[n] & out_latch_q[n] & ~pullup_global_off_q);
			assign pin_input_enable[n] = ovr.input_gate_override_enable[n]
				? ovr.input_gate_override_value[n] : ~sleep_mode;
		end
	endgenerate

	// ======================================================================
	// Register reads, data in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_rdata_q <= pamux_pkg::READ_ZERO;
		end else if (bus_re) begin
			unique case (bus_addr)
				pamux_pkg::REG_CTRL: begin
					bus_rdata_q <= pamux_pkg::READ_ZERO;
					bus_rdata_q[pamux_pkg::CTRL_EME_BIT] <= ext_mem_enable_q;
					bus_rdata_q[pamux_pkg::CTRL_PUD_BIT] <= pullup_global_off_q;
				end
				pamux_pkg::REG_LATCH:  bus_rdata_q <= out_latch_q;
				pamux_pkg::REG_DIR:    bus_rdata_q <= direction_q;
				pamux_pkg::REG_PINS:   bus_rdata_q <= pin_state_q;
				pamux_pkg::REG_MADDR:  bus_rdata_q <= mem_addr_q;
				pamux_pkg::REG_MWDATA: bus_rdata_q <= mem_wdata_q;
				pamux_pkg::REG_MSTAT: begin
					bus_rdata_q <= pamux_pkg::READ_ZERO;
					bus_rdata_q[pamux_pkg::STAT_BUSY_BIT] <= state_q != PAMUX_IDLE_A;
					bus_rdata_q[pamux_pkg::STAT_DONE_BIT] <= mem_done_q;
				end
				pamux_pkg::REG_MRDATA: bus_rdata_q <= mem_rdata_q;
				default:               bus_rdata_q <= pamux_pkg::READ_ZERO;
			endcase
		end else begin
			bus_rdata_q <= pamux_pkg::READ_ZERO;
		end
	end

	assign bus_rdata = bus_rdata_q;

endmodule

// [bench/pamux_assertions.sv]
// Port-level checks for the Port A pin override top
`timescale 1ns/1ps
module pamux_assertions #(
	parameter int ADDR_CYC = 2,
	parameter int DATA_CYC = 3
) (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       bus_re,
	input wire logic [7:0] bus_rdata,
	input wire logic       sleep_mode,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pin_pullup_on,
	input wire logic [7:0] pin_input_enable,
	input wire logic       address_phase,
	input wire logic       write_phase,
	input wire logic       read_phase
);
	logic [7:0] a_cnt_q;
	logic [7:0] d_cnt_q;
	logic       data_ph;
	assign data_ph = write_phase | read_phase;
	// ==================================================================
	// Phase length counters
	always_ff @(posedge clk) begin
		if (rst || !address_phase)
			a_cnt_q <= 8'h00;
		else
			a_cnt_q <= a_cnt_q + 8'h01;
	end
	always_ff @(posedge clk) begin
		if (rst || !data_ph)
			d_cnt_q <= 8'h00;
		else
			d_cnt_q <= d_cnt_q + 8'h01;
	end
	// ==================================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_data;
		data_ph && !address_phase;
	endsequence
	sequence s_idle;
		!address_phase && !data_ph;
	endsequence
	AST_IN_GATE: assert property (pin_input_enable == ~{8{sleep_mode}})
		else $error("input enable not following sleep");
	AST_ADDR_DRIVE: assert property (address_phase |-> pin_oe_n == 8'h00)
		else $error("pins not driven in address phase");
	AST_WR_DRIVE: assert property (write_phase |-> pin_oe_n == 8'h00)
		else $error("pins not driven in write phase");
	AST_RD_RELEASE: assert property (read_phase |-> pin_oe_n == 8'hFF)
		else $error("pins driven in read phase");
	AST_PULLUP_OFF: assert property (address_phase || write_phase |-> pin_pullup_on == 8'h00)
		else $error("pull-up on while driving");
	AST_PHASE_ONE: assert property ($onehot0({address_phase, write_phase, read_phase}))
		else $error("phases overlap");
	AST_ADDR_LEN: assert property ($fell(address_phase) |-> a_cnt_q == ADDR_CYC ##0 s_data)
		else $error("address phase length or follow-up wrong");
	AST_DATA_LEN: assert property ($fell(data_ph) |-> d_cnt_q == DATA_CYC ##0 s_idle)
		else $error("data phase length wrong");
	AST_WR_HOLD: assert property (write_phase && $past(write_phase) |-> $stable(pin_out))
		else $error("write data moved");
	AST_RDATA_ZERO: assert property (!$past(bus_re) |-> bus_rdata == 8'h00)
		else $error("read data outside its cycle");
endmodule

bind pamux_top pamux_assertions #(.ADDR_CYC(ADDR_CYC), .DATA_CYC(DATA_CYC)) u_chk (
	.clk(clk), .rst(rst), .bus_re(bus_re), .bus_rdata(bus_rdata), .sleep_mode(sleep_mode),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_on(pin_pullup_on),
	.pin_input_enable(pin_input_enable), .address_phase(address_phase),
	.write_phase(write_phase), .read_phase(read_phase)
);

// [bench/pamux_mem_model.sv]
// External parallel memory on the multiplexed Port A bus
`timescale 1ns/1ps
module pamux_mem_model (
	input wire logic       clk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pin_pullup_on,
	input wire logic       address_phase,
	input wire logic       write_phase,
	input wire logic       read_phase,
	output logic     [7:0] pin_in
);
	logic [7:0] mem [0:255];
	logic [7:0] addr_q;
	logic [7:0] tog_q;
	logic [7:0] far;
	initial tog_q = 8'h5A;
	// ==================================================================
	// Address latch, write capture, read drive
	always @(posedge clk) begin
		if (address_phase)
			addr_q <= pin_out;
		if (write_phase)
			mem[addr_q] <= pin_out;
		tog_q <= {tog_q[6:0], ~tog_q[7]};
	end
	always_comb begin
		far = read_phase ? mem[addr_q] : (pin_pullup_on | tog_q);
		for (int i = 0; i < 8; i++)
			pin_in[i] = pin_oe_n[i] ? far[i] : pin_out[i];
	end
endmodule

// [bench/tb_pamux_top.sv]
// Self-checking bench for the Port A pin override top
`timescale 1ns/1ps
module tb_pamux_top;
	localparam int A_CYC = 2;
	// Data phase long enough for read data to cross the three-stage pin filter
	localparam int D_CYC = 5;
	logic       clk, rst, bus_we, bus_re, sleep_mode;
	logic [7:0] bus_addr, bus_wdata, bus_rdata, pin_in, pin_out;
	logic [7:0] pin_oe_n, pin_pullup_on, pin_input_enable;
	logic       address_phase, write_phase, read_phase;
	int         miscompares, n_tests;

	pamux_top #(.ADDR_CYC(A_CYC), .DATA_CYC(D_CYC)) uut (
		.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we),
		.bus_re(bus_re), .bus_rdata(bus_rdata), .sleep_mode(sleep_mode), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_on(pin_pullup_on),
		.pin_input_enable(pin_input_enable), .address_phase(address_phase),
		.write_phase(write_phase), .read_phase(read_phase)
	);
	pamux_mem_model u_mem (
		.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_on(pin_pullup_on),
		.address_phase(address_phase), .write_phase(write_phase),
		.read_phase(read_phase), .pin_in(pin_in)
	);

	// ==================================================================
	// Bus and compare tasks
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_we <= 1'b1;
		@(posedge clk);
		bus_we <= 1'b0;
	endtask
	task bus_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		bus_addr <= a;
		bus_re <= 1'b1;
		@(posedge clk);
		bus_re <= 1'b0;
		@(negedge clk);
		chk(bus_rdata, exp, what);
	endtask
	task summarize;
		$display("Checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==================================================================
	// Scenarios
	task t_reset;
		bus_rd(pamux_pkg::REG_CTRL, 8'h00, "ctrl");
		bus_rd(8'h24, 8'h00, "unmapped");
		chk(pin_oe_n, 8'hFF, "oe after reset");
		chk(pin_pullup_on, 8'h00, "pullup after reset");
	endtask
	task t_gpio;
		bus_wr(pamux_pkg::REG_LATCH, 8'hF0);
		bus_wr(pamux_pkg::REG_DIR, 8'h3C);
		bus_wr(pamux_pkg::REG_MCMD, 8'h03);
		@(negedge clk);
		chk({7'h00, address_phase}, 8'h00, "start while disabled");
		chk(pin_oe_n, 8'hC3, "gpio oe");
		chk(pin_out, 8'hF0, "gpio level");
		chk(pin_pullup_on, 8'hC0, "gpio pullup");
		bus_rd(pamux_pkg::REG_MSTAT, 8'h00, "status idle");
		bus_wr(pamux_pkg::REG_CTRL, 8'h02);
		@(negedge clk);
		chk(pin_pullup_on, 8'h00, "pullup global off");
		@(posedge clk);
		sleep_mode <= 1'b1;
		@(negedge clk);
		chk(pin_input_enable, 8'h00, "input gate asleep");
		@(posedge clk);
		sleep_mode <= 1'b0;
		@(negedge clk);
		chk(pin_input_enable, 8'hFF, "input gate awake");
	endtask
	task t_ext_idle;
		bus_wr(pamux_pkg::REG_CTRL, 8'h01);
		@(negedge clk);
		chk(pin_oe_n, 8'hFF, "ext idle oe");
		chk(pin_pullup_on, 8'h00, "ext pullup pud 0");
		bus_wr(pamux_pkg::REG_CTRL, 8'h03);
		@(negedge clk);
		chk(pin_pullup_on, 8'hF0, "ext pullup pud 1");
	endtask
	task mem_op(input logic [7:0] a, input logic [7:0] d, input logic wr);
		bus_wr(pamux_pkg::REG_MADDR, a);
		bus_wr(pamux_pkg::REG_MWDATA, d);
		bus_wr(pamux_pkg::REG_MCMD, {6'h00, wr, 1'b1});
		repeat (A_CYC) begin
			@(negedge clk);
			chk({7'h00, address_phase}, 8'h01, "address phase");
			chk(pin_out, a, "address on pins");
			chk(pin_oe_n, 8'h00, "address drive");
		end
		repeat (D_CYC) begin
			@(negedge clk);
			chk({6'h00, write_phase, read_phase}, {6'h00, wr, ~wr}, "data phase");
			chk(pin_oe_n, wr ? 8'h00 : 8'hFF, "data drive");
			if (wr)
				chk(pin_out, d, "write data on pins");
		end
		@(negedge clk);
		chk({5'h00, address_phase, write_phase, read_phase}, 8'h00, "back to idle");
		bus_rd(pamux_pkg::REG_MSTAT, 8'h02, "done");
		bus_wr(pamux_pkg::REG_MSTAT, 8'h02);
		if (!wr)
			bus_rd(pamux_pkg::REG_MRDATA, d, "read data");
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("Error at %0t: timeout", $time);
		summarize();
	end
	initial begin
		rst = 1'b1;
		bus_we = 1'b0;
		bus_re = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		sleep_mode = 1'b0;
		miscompares = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_gpio();
		t_ext_idle();
		mem_op(8'h5A, 8'hC3, 1'b1);
		mem_op(8'hA5, 8'h3C, 1'b1);
		mem_op(8'h5A, 8'hC3, 1'b0);
		mem_op(8'hA5, 8'h3C, 1'b0);
		summarize();
	end
endmodule
